// >>> src/eipl_pkg.sv
// Package: register map, field positions and reset values of the pin latch
//
// How it works
// - A low interrupt pin can set the request latch; acknowledge or reset clears it.
// - With level sense on, clearing needs an acknowledge and the pin back high.
// - Fetching this interrupt's vector makes an acknowledge pulse clearing the latch.
// - Writing one to the acknowledge bit acts like a vector fetch.
// - A falling edge after a software acknowledge sets the latch again.
// - Unmasked service loads the program counter from the two fixed vector bytes.
// - In level mode the request stays pending while the pin is low.
// - Reset clears the latch and the sense select, even with pin low.
// - Edge-only mode: falling edges set; an acknowledge clears at once unless a falling edge comes in the same cycle.
// - The pending flag ignores the mask so software can poll.
// - Current pin level is offered to the branch-on-pin instructions.
// - In break, software acknowledge clears only with break clear enable set.
// - With break clear enable zero, break-state acknowledge writes do not clear the latch.
// - Pending flag is read-only, one when pending, zero otherwise.
// - Acknowledge bit is write-only, reads zero, cleared by reset.
// - Mask bit read/write; one disables requests; reset clears it.
// - Sense select read/write; one edge plus level, zero edge only.
// - Latched request goes to priority logic only while the mask is clear.
package eipl_pkg;

  // Avalon word byte addresses of the registers
  localparam logic [3:0] EIPL_STATUS_CONTROL_ADDR = 4'h0;
  localparam logic [3:0] EIPL_BREAK_FLAG_CTRL_ADDR = 4'h4;
  localparam logic [3:0] EIPL_VECTOR_ADDR = 4'h8;

  // Field positions inside the status and control register
  localparam int EIPL_BIT_PENDING = 3;
  localparam int EIPL_BIT_ACK = 2;
  localparam int EIPL_BIT_MASK = 1;
  localparam int EIPL_BIT_SENSE = 0;
  // Field position inside the break flag control register
  localparam int EIPL_BIT_BREAK_CLEAR_EN = 7;

  // Fixed vector locations of this interrupt
  localparam logic [15:0] EIPL_VECTOR_HI_LOC = 16'hFFFA;
  localparam logic [15:0] EIPL_VECTOR_LO_LOC = 16'hFFFB;

  // Reset values
  localparam logic        EIPL_RST_MASK = 1'h0;
  localparam logic        EIPL_RST_SENSE = 1'h0;
  localparam logic        EIPL_RST_BREAK_CLEAR_EN = 1'h0;
  localparam logic        EIPL_RST_PIN_SYNC = 1'h1;
  localparam logic [15:0] EIPL_RST_VECTOR = 16'h0000;

  // Bus answer timing: a read or write completes in this many wait cycles
  localparam int EIPL_WAIT_CYCLES = 1;

endpackage

// >>> src/eipl_sync.sv
// Two-stage synchroniser for one asynchronous level
`timescale 1ns/1ps
`default_nettype none

module eipl_sync (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic async_i,
  output var  logic sync_o
);

  logic meta_q;

  // First stage feeds only the second stage; the stages keep sampling
  // through reset so a pin held low across reset shows no false edge
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
    else
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule

`default_nettype wire

// >>> src/eipl_top.sv
// External interrupt pin latch with Avalon-MM register access
//
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

module eipl_top (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // Active-low interrupt pin from outside
  input  wire logic        irq_pin_n_i,
  // CPU side
  input  wire logic        vector_fetch_i,
  input  wire logic        break_state_i,
  output var  logic        cpu_irq_req_o,
  output var  logic        branch_if_pin_high_o,
  output var  logic        branch_if_pin_low_o,
  output var  logic [15:0] vector_hi_loc_o,
  output var  logic [15:0] vector_lo_loc_o,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output var  logic [31:0] avs_readdata_o,
  output var  logic        avs_waitrequest_o
);

  typedef struct packed {
    logic        pin_prev;
    logic        latch;
    logic        ack_pend;
    logic        mask;
    logic        sense;
    logic        break_clear_en;
    logic        busy;
    logic        cpu_irq;
    logic        pin_high;
    logic        pin_low;
    logic [31:0] rdata;
    logic        waitreq;
  } eipl_state_t;

  eipl_state_t s_q;
  eipl_state_t s_d;
  logic        pin_sync;
  logic        falling;
  logic        sw_ack;
  logic        ack;
  logic        access;
  logic [31:0] rd_mux;

  // Pin crosses into the bus clock before anything reads it
  eipl_sync u_pin_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (irq_pin_n_i),
    .sync_o    (pin_sync)
  );

  // Bus request is taken on the cycle waitrequest is dropped
  assign access = (avs_read_i | avs_write_i) & s_q.busy;

  // Edge found against the previous synchronised sample
  assign falling = s_q.pin_prev & ~pin_sync;

  // Software acknowledge, gated off in break unless clearing is enabled
  assign sw_ack = access & avs_write_i & avs_byteenable_i[0]
                & (avs_address_i == eipl_pkg::EIPL_STATUS_CONTROL_ADDR)
                & avs_writedata_i[eipl_pkg::EIPL_BIT_ACK]
                & (~break_state_i | s_q.break_clear_en);
  // Vector fetch and software write share one acknowledge
  assign ack = vector_fetch_i | sw_ack;

  // Read data mux; acknowledge reads zero, pending is live latch state
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (avs_address_i)
      eipl_pkg::EIPL_STATUS_CONTROL_ADDR:
      begin
        rd_mux[eipl_pkg::EIPL_BIT_PENDING] = s_q.latch;
        rd_mux[eipl_pkg::EIPL_BIT_ACK] = 1'h0;
        rd_mux[eipl_pkg::EIPL_BIT_MASK] = s_q.mask;
        rd_mux[eipl_pkg::EIPL_BIT_SENSE] = s_q.sense;
      end
      eipl_pkg::EIPL_BREAK_FLAG_CTRL_ADDR:
      begin
        rd_mux[eipl_pkg::EIPL_BIT_BREAK_CLEAR_EN] = s_q.break_clear_en;
      end
      eipl_pkg::EIPL_VECTOR_ADDR:
      begin
        rd_mux[31:16] = eipl_pkg::EIPL_VECTOR_HI_LOC;
        rd_mux[15:0] = eipl_pkg::EIPL_VECTOR_LO_LOC;
      end
      default:
      begin
        rd_mux = 32'h0000_0000; // Unmapped reads return zero
      end
    endcase
  end

  // Next state of the whole block
  always_comb
  begin
    s_d = s_q;
    s_d.pin_prev = pin_sync;

    // Latch: set wins over a same-cycle acknowledge so no edge is lost.
    // An acknowledge seen while a low pin holds the latch is remembered,
    // so acknowledge and pin release may come in either order.
    if (falling)
    begin
      s_d.latch = 1'h1;
      s_d.ack_pend = 1'h0;
    end
    else if (s_q.sense & ~pin_sync)
    begin
      s_d.latch = 1'h1;
      if (ack)
      begin
        s_d.ack_pend = 1'h1;
      end
    end
    else if (ack | s_q.ack_pend)
    begin
      s_d.latch = 1'h0;
      s_d.ack_pend = 1'h0;
    end

    // Register writes
    if (access & avs_write_i & avs_byteenable_i[0])
    begin
      if (avs_address_i == eipl_pkg::EIPL_STATUS_CONTROL_ADDR)
      begin
        s_d.mask = avs_writedata_i[eipl_pkg::EIPL_BIT_MASK];
        s_d.sense = avs_writedata_i[eipl_pkg::EIPL_BIT_SENSE];
      end
      else if (avs_address_i == eipl_pkg::EIPL_BREAK_FLAG_CTRL_ADDR)
      begin
        s_d.break_clear_en =
          avs_writedata_i[eipl_pkg::EIPL_BIT_BREAK_CLEAR_EN];
      end
    end

    // One wait cycle, then answer; readdata stands with waitrequest low
    s_d.busy = (avs_read_i | avs_write_i) & ~s_q.busy;
    s_d.waitreq = ~s_d.busy;
    s_d.rdata = (avs_read_i & s_d.busy) ? rd_mux : 32'h0000_0000;
    if ((avs_read_i | avs_write_i) & ~s_q.busy)
    begin
      s_d.waitreq = 1'h0;
    end
    else
    begin
      s_d.waitreq = 1'h1;
    end
    if (avs_read_i & ~s_q.busy)
    begin
      s_d.rdata = rd_mux;
    end

    // Request forwarded only while unmasked
    s_d.cpu_irq = s_d.latch & ~s_d.mask;
    // Pin level for the branch-on-pin instructions
    s_d.pin_high = pin_sync;
    s_d.pin_low = ~pin_sync;
  end

  // State register; reset drops latch and sense even with pin low
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      s_q.pin_prev <= pin_sync; // Tracks the pin so no edge follows reset
      s_q.latch <= 1'h0;
      s_q.ack_pend <= 1'h0;
      s_q.mask <= eipl_pkg::EIPL_RST_MASK;
      s_q.sense <= eipl_pkg::EIPL_RST_SENSE;
      s_q.break_clear_en <= eipl_pkg::EIPL_RST_BREAK_CLEAR_EN;
      s_q.busy <= 1'h0;
      s_q.cpu_irq <= 1'h0;
      s_q.pin_high <= eipl_pkg::EIPL_RST_PIN_SYNC;
      s_q.pin_low <= 1'h0;
      s_q.rdata <= 32'h0000_0000;
      s_q.waitreq <= 1'h1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign cpu_irq_req_o = s_q.cpu_irq;
  assign branch_if_pin_high_o = s_q.pin_high;
  assign branch_if_pin_low_o = s_q.pin_low;
  assign vector_hi_loc_o = eipl_pkg::EIPL_VECTOR_HI_LOC;
  assign vector_lo_loc_o = eipl_pkg::EIPL_VECTOR_LO_LOC;
  assign avs_readdata_o = s_q.rdata;
  assign avs_waitrequest_o = s_q.waitreq;

endmodule

`default_nettype wire

// >>> verification/eipl_monitor.sv
// Port checker for the interrupt pin latch
`timescale 1ns/1ps
`default_nettype none
module eipl_monitor (
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic        irq_pin_n_i,
  input wire logic        vector_fetch_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic        avs_waitrequest_o,
  input wire logic        cpu_irq_req_o,
  input wire logic        branch_if_pin_high_o,
  input wire logic        branch_if_pin_low_o,
  input wire logic [15:0] vector_hi_loc_o,
  input wire logic [15:0] vector_lo_loc_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Five quiet cycles flush the two synchroniser stages
  sequence pin_quiet; irq_pin_n_i[*5]; endsequence
  sequence fetch_quiet; pin_quiet ##0 vector_fetch_i ##1 irq_pin_n_i[*2];
  endsequence
  chk_vec_hi: assert property (vector_hi_loc_o == 16'hFFFA)
    else $error("vector high location wrong");
  chk_vec_lo: assert property (vector_lo_loc_o == 16'hFFFB)
    else $error("vector low location wrong");
  chk_pin_pair: assert property
    (branch_if_pin_low_o != branch_if_pin_high_o)
    else $error("pin level outputs agree");
  chk_pin_low: assert property
    ((!irq_pin_n_i)[*5] |-> branch_if_pin_low_o)
    else $error("low pin not shown");
  chk_pin_high: assert property (pin_quiet |-> branch_if_pin_high_o)
    else $error("high pin not shown");
  chk_fetch_clear: assert property (fetch_quiet |=> !cpu_irq_req_o)
    else $error("fetch left request up");
  chk_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  chk_wait_cause: assert property
    ($fell(avs_waitrequest_o) |-> $past(avs_read_i || avs_write_i))
    else $error("answer without request");
endmodule
bind eipl_top eipl_monitor i_mon (.*);
`default_nettype wire

// >>> verification/eipl_irq_src.sv
// External source driving the active-low interrupt pin
`timescale 1ns/1ps
`default_nettype none
module eipl_irq_src (
  input  wire logic clk_i,
  output var  logic pin_n_o
);
  initial pin_n_o = 1'h1;
  // Changes just after an edge, then holds for a chosen time
  task automatic drive(input logic lvl, input int hold);
    @(posedge clk_i);
    pin_n_o <= lvl;
    repeat (hold) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// >>> verification/eipl_bench.sv
// Self-checking bench for the interrupt pin latch
`timescale 1ns/1ps
`default_nettype none
module eipl_bench;
  localparam logic [3:0] SC = eipl_pkg::EIPL_STATUS_CONTROL_ADDR;
  localparam logic [3:0] BF = eipl_pkg::EIPL_BREAK_FLAG_CTRL_ADDR;
  logic        clk_i = 1'h0;
  logic        sys_rst_i = 1'h1;
  logic        fetch = 1'h0;
  logic        brk = 1'h0;
  logic        rd = 1'h0;
  logic        wr = 1'h0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic        pin_n;
  logic        wreq;
  logic        irq;
  logic        pin_hi;
  int          failures = 0;
  int          checks = 0;
  always #12.5 clk_i = ~clk_i;
  eipl_irq_src i_src (.clk_i(clk_i), .pin_n_o(pin_n));
  eipl_top i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .irq_pin_n_i(pin_n),
    .vector_fetch_i(fetch), .break_state_i(brk), .cpu_irq_req_o(irq),
    .branch_if_pin_high_o(pin_hi), .branch_if_pin_low_o(),
    .vector_hi_loc_o(), .vector_lo_loc_o(), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq));
  task automatic wrap_up();
    if (failures == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is seen low; an idle edge follows
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    rd <= ~w;
    wr <= w;
    adr <= a;
    wd <= d;
    @(posedge clk_i);
    while (wreq !== 1'h0)
    begin
      n++;
      if (n > 50)
      begin
        failures++;
        wrap_up();
      end
      @(posedge clk_i);
    end
    q = rdat;
    rd <= 1'h0;
    wr <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'h0, a, 32'h0, q);
    cmp(q, e);
  endtask
  task automatic t_reset();
    rchk(SC, 32'h0);
    rchk(BF, 32'h0);
    rchk(4'h8, 32'hFFFAFFFB);
    rchk(4'hC, 32'h0);
  endtask
  task automatic t_edge();
    i_src.drive(1'h0, 6);
    cmp(irq, 1'h1);
    cmp(pin_hi, 1'h0);
    i_src.drive(1'h1, 4);
    rchk(SC, 32'h8);
    wreg(SC, 32'h4);
    rchk(SC, 32'h0);
    i_src.drive(1'h0, 6);
    rchk(SC, 32'h8);
    i_src.drive(1'h1, 4);
    fetch <= 1'h1;
    @(posedge clk_i);
    fetch <= 1'h0;
    rchk(SC, 32'h0);
  endtask
  task automatic t_mask();
    wreg(SC, 32'h2);
    i_src.drive(1'h0, 6);
    cmp(irq, 1'h0);
    rchk(SC, 32'hA);
    wreg(SC, 32'h0);
    repeat (2) @(posedge clk_i);
    cmp(irq, 1'h1);
    wreg(SC, 32'h4);
    i_src.drive(1'h1, 4);
    rchk(SC, 32'h0);
  endtask
  task automatic t_level();
    wreg(SC, 32'h1);
    i_src.drive(1'h0, 6);
    wreg(SC, 32'h7);
    rchk(SC, 32'hB);
    i_src.drive(1'h1, 4);
    rchk(SC, 32'h3);
    wreg(SC, 32'h1);
    i_src.drive(1'h0, 6);
    i_src.drive(1'h1, 4);
    rchk(SC, 32'h9);
    wreg(SC, 32'h5);
    rchk(SC, 32'h1);
    i_src.drive(1'h0, 6);
    sys_rst_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'h0;
    @(posedge clk_i);
    rchk(SC, 32'h0);
    i_src.drive(1'h1, 4);
  endtask
  task automatic t_break();
    brk <= 1'h1;
    i_src.drive(1'h0, 6);
    wreg(SC, 32'h4);
    rchk(SC, 32'h8);
    wreg(BF, 32'h80);
    wreg(SC, 32'h4);
    brk <= 1'h0;
    rchk(SC, 32'h0);
    i_src.drive(1'h1, 4);
  endtask
  initial
  begin
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'h0;
    @(posedge clk_i);
    t_reset();
    t_edge();
    t_mask();
    t_level();
    t_break();
    wrap_up();
  end
endmodule
`default_nettype wire
